// ### rtl/csd_pkg.sv
// Package: constants shared by the chip-select decoder
`default_nettype none
package csd_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 16;
	localparam int NUM_GROUPS = 4;
	localparam int SEL_PER_GROUP = 4;
	localparam int NUM_SEL = 16;
	localparam int WAIT_W = 3;
	localparam logic [2:0] MAX_WAIT = 3'h6;
	localparam logic [2:0] WAIT_EXT = 3'h7;
	// Finest block granularity: groups A/B bit 16 and up, C/D bit 12 and up
	localparam int MEM_GRAN_LSB = 16;
	localparam int PER_GRAN_LSB = 12;
	localparam int GROUP_A = 0;
	localparam int GROUP_D = 3;
	localparam int BOOT_IDX = 0;
	localparam int CARD_IDX = 15;
	localparam logic [15:0] SEL_EN_RESET = 16'h0001;
	localparam logic [31:0] BOOT_MASK_RESET = 32'hffff_ffff;
	localparam logic [2:0] BOOT_WAIT_RESET = 3'h6;
	localparam logic BOOT_WIDE_RESET = 1'b1;
	typedef enum logic [2:0] {
		CSD_IDLE = 3'b001,
		CSD_WAIT = 3'b010,
		CSD_DONE = 3'b100
	} csd_state_t;
endpackage
`default_nettype wire

// ### rtl/csd_match.sv
// Address match for one chip select against its group and its own window
`timescale 1ns/1ps
`default_nettype none
module csd_match #(
	parameter int GRAN_LSB = 12
) (
	input wire logic [31:0] addr,
	input wire logic [31:0] group_base,
	input wire logic [31:0] group_mask,
	input wire logic [31:0] sel_cmp,
	input wire logic [31:0] sel_mask,
	input wire logic enable,
	output logic hit
);
	logic [31:0] gran_mask;
	logic [31:0] gm;
	logic [31:0] sm;
	always_comb begin
		// Bits below the granularity never take part in the decode
		gran_mask = ~((32'h1 << GRAN_LSB) - 32'h1);
		gm = ~group_mask & gran_mask;
		sm = ~sel_mask & gran_mask;
		hit = enable && (((addr ^ group_base) & gm) == 32'h0) && (((addr ^ sel_cmp) & sm) == 32'h0);
	end
endmodule // csd_match
`default_nettype wire

// ### rtl/csd_decoder.sv
// Chip-select and memory-strobe generator for a 16-bit data processor bus
`timescale 1ns/1ps
`default_nettype none
module csd_decoder #(
	parameter int ADDR_W = csd_pkg::ADDR_W,
	parameter int NUM_SEL = csd_pkg::NUM_SEL
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic bus_strobe,
	input wire logic bus_read,
	input wire logic bus_upper,
	input wire logic bus_lower,
	input wire logic transfer_acknowledge_n,
	input wire logic cfg_load,
	input wire logic [ADDR_W-1:0] cfg_group_base [csd_pkg::NUM_GROUPS],
	input wire logic [ADDR_W-1:0] cfg_group_mask [csd_pkg::NUM_GROUPS],
	input wire logic [ADDR_W-1:0] cfg_sel_cmp [NUM_SEL],
	input wire logic [ADDR_W-1:0] cfg_sel_mask [NUM_SEL],
	input wire logic [NUM_SEL-1:0] cfg_sel_enable,
	input wire logic [NUM_SEL-1:0] cfg_sel_wide,
	input wire logic [2:0] cfg_sel_wait [NUM_SEL],
	output logic [NUM_SEL-1:0] chip_select_n,
	output logic boot_select,
	output logic card_slot_select,
	output logic read_output_enable_n,
	output logic upper_byte_write_strobe_n,
	output logic lower_byte_write_strobe_n,
	output logic cycle_done,
	output logic cycle_wide
);
	// Transfer acknowledge comes from a pin, so it is synchronised first
	logic ack_s1_reg;
	logic ack_s2_reg;
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack_s1_reg <= 1'b1;
			ack_s2_reg <= 1'b1;
		end else begin
			ack_s1_reg <= transfer_acknowledge_n;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	// Configuration registers
	logic [ADDR_W-1:0] gbase_reg [csd_pkg::NUM_GROUPS];
	logic [ADDR_W-1:0] gmask_reg [csd_pkg::NUM_GROUPS];
	logic [ADDR_W-1:0] scmp_reg [NUM_SEL];
	logic [ADDR_W-1:0] smask_reg [NUM_SEL];
	logic [NUM_SEL-1:0] sen_reg;
	logic [NUM_SEL-1:0] swide_reg;
	logic [2:0] swait_reg [NUM_SEL];
	logic [ADDR_W-1:0] gbase_next [csd_pkg::NUM_GROUPS];
	logic [ADDR_W-1:0] gmask_next [csd_pkg::NUM_GROUPS];
	logic [ADDR_W-1:0] scmp_next [NUM_SEL];
	logic [ADDR_W-1:0] smask_next [NUM_SEL];
	logic [NUM_SEL-1:0] sen_next;
	logic [NUM_SEL-1:0] swide_next;
	logic [2:0] swait_next [NUM_SEL];

	always_comb begin
		gbase_next = gbase_reg;
		gmask_next = gmask_reg;
		scmp_next = scmp_reg;
		smask_next = smask_reg;
		sen_next = sen_reg;
		swide_next = swide_reg;
		swait_next = swait_reg;
		if (cfg_load) begin
			gbase_next = cfg_group_base;
			gmask_next = cfg_group_mask;
			scmp_next = cfg_sel_cmp;
			smask_next = cfg_sel_mask;
			sen_next = cfg_sel_enable;
			swide_next = cfg_sel_wide;
			swait_next = cfg_sel_wait;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			for (int g = 0; g < csd_pkg::NUM_GROUPS; g++) begin
				gbase_reg[g] <= '0;
				gmask_reg[g] <= '0;
			end
			for (int s = 0; s < NUM_SEL; s++) begin
				scmp_reg[s] <= '0;
				smask_reg[s] <= '0;
				swait_reg[s] <= csd_pkg::WAIT_EXT;
			end
			// Boot select decodes the whole space until software narrows it
			gmask_reg[csd_pkg::GROUP_A] <= csd_pkg::BOOT_MASK_RESET;
			smask_reg[csd_pkg::BOOT_IDX] <= csd_pkg::BOOT_MASK_RESET;
			swait_reg[csd_pkg::BOOT_IDX] <= csd_pkg::BOOT_WAIT_RESET;
			sen_reg <= csd_pkg::SEL_EN_RESET;
			swide_reg <= {NUM_SEL{1'b0}};
			swide_reg[csd_pkg::BOOT_IDX] <= csd_pkg::BOOT_WIDE_RESET;
		end else begin
			gbase_reg <= gbase_next;
			gmask_reg <= gmask_next;
			scmp_reg <= scmp_next;
			smask_reg <= smask_next;
			sen_reg <= sen_next;
			swide_reg <= swide_next;
			swait_reg <= swait_next;
		end
	end

	// Address decode, one matcher per select
	logic [NUM_SEL-1:0] hit;
	for (genvar i = 0; i < NUM_SEL; i++) begin : g_sel
		localparam int GRP = i / csd_pkg::SEL_PER_GROUP;
		localparam int GRAN = (GRP < 2) ? csd_pkg::MEM_GRAN_LSB : csd_pkg::PER_GRAN_LSB;
		csd_match #(.GRAN_LSB(GRAN)) u_match (
			.addr(bus_addr),
			.group_base(gbase_reg[GRP]),
			.group_mask(gmask_reg[GRP]),
			.sel_cmp(scmp_reg[i]),
			.sel_mask(smask_reg[i]),
			.enable(sen_reg[i]),
			.hit(hit[i])
		);
	end

	// Lowest-numbered hit wins so only one select ever drives
	logic [NUM_SEL-1:0] pick;
	logic [3:0] pick_idx;
	always_comb begin
		pick = '0;
		pick_idx = 4'h0;
		for (int s = NUM_SEL - 1; s >= 0; s--) begin
			if (hit[s]) begin
				pick = '0;
				pick[s] = 1'b1;
				pick_idx = 4'(s);
			end
		end
	end

	// Cycle sequencer
	csd_pkg::csd_state_t state_reg;
	csd_pkg::csd_state_t state_next;
	logic [NUM_SEL-1:0] sel_reg;
	logic [NUM_SEL-1:0] sel_next;
	logic [3:0] idx_reg;
	logic [3:0] idx_next;
	logic [2:0] wcnt_reg;
	logic [2:0] wcnt_next;
	logic rd_reg;
	logic rd_next;
	logic up_reg;
	logic up_next;
	logic lo_reg;
	logic lo_next;

	always_comb begin
		state_next = state_reg;
		sel_next = sel_reg;
		idx_next = idx_reg;
		wcnt_next = wcnt_reg;
		rd_next = rd_reg;
		up_next = up_reg;
		lo_next = lo_reg;
		unique case (state_reg)
			csd_pkg::CSD_IDLE: begin
				if (bus_strobe && (hit != '0)) begin
					sel_next = pick;
					idx_next = pick_idx;
					rd_next = bus_read;
					up_next = bus_upper;
					lo_next = bus_lower;
					wcnt_next = swait_reg[pick_idx];
					state_next = csd_pkg::CSD_WAIT;
				end
			end
			csd_pkg::CSD_WAIT: begin
				if (swait_reg[idx_reg] == csd_pkg::WAIT_EXT) begin
					if (!ack_s2_reg) begin
						state_next = csd_pkg::CSD_DONE;
					end
				end else if (wcnt_reg == 3'h0) begin
					state_next = csd_pkg::CSD_DONE;
				end else begin
					wcnt_next = wcnt_reg - 3'h1;
				end
			end
			csd_pkg::CSD_DONE: begin
				// Hold off a new cycle until the processor drops its strobe
				if (!bus_strobe) begin
					sel_next = '0;
					rd_next = 1'b0;
					up_next = 1'b0;
					lo_next = 1'b0;
					state_next = csd_pkg::CSD_IDLE;
				end
			end
			default: begin
				sel_next = '0;
				state_next = csd_pkg::CSD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= csd_pkg::CSD_IDLE;
			sel_reg <= '0;
			idx_reg <= 4'h0;
			wcnt_reg <= 3'h0;
			rd_reg <= 1'b0;
			up_reg <= 1'b0;
			lo_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sel_reg <= sel_next;
			idx_reg <= idx_next;
			wcnt_reg <= wcnt_next;
			rd_reg <= rd_next;
			up_reg <= up_next;
			lo_reg <= lo_next;
		end
	end

	// Strobes stay asserted from the cycle start until the strobe is seen low in the done state
	assign chip_select_n = ~sel_reg;
	assign boot_select = sel_reg[csd_pkg::BOOT_IDX];
	assign card_slot_select = sel_reg[csd_pkg::CARD_IDX];
	assign read_output_enable_n = ~(rd_reg && (sel_reg != '0));
	// A narrow device only has the lower lane, so its write always uses that strobe
	assign upper_byte_write_strobe_n = ~(!rd_reg && up_reg && swide_reg[idx_reg]
		&& (sel_reg != '0));
	assign lower_byte_write_strobe_n = ~(!rd_reg && (sel_reg != '0)
		&& (lo_reg || (up_reg && !swide_reg[idx_reg])));
	assign cycle_done = (state_reg == csd_pkg::CSD_DONE);
	assign cycle_wide = swide_reg[idx_reg];
endmodule // csd_decoder
`default_nettype wire

// ### verif/csd_decoder_assertions.sv
// Checker for the chip-select decoder outputs
`timescale 1ns/1ps
`default_nettype none
module csd_decoder_checker (
	input wire logic clock,
	input wire logic nrst,
	input wire logic bus_strobe,
	input wire logic [15:0] chip_select_n,
	input wire logic boot_select,
	input wire logic card_slot_select,
	input wire logic read_output_enable_n,
	input wire logic upper_byte_write_strobe_n,
	input wire logic lower_byte_write_strobe_n,
	input wire logic cycle_done
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wire any_cs = chip_select_n != 16'hffff;
	wire we_hi = upper_byte_write_strobe_n && lower_byte_write_strobe_n;
	property p_one;
		$onehot0(~chip_select_n);
	endproperty
	a_one: assert property (p_one) else $error("two selects");
	property p_boot;
		boot_select == !chip_select_n[0];
	endproperty
	a_boot: assert property (p_boot) else $error("boot copy");
	property p_card;
		card_slot_select == !chip_select_n[15];
	endproperty
	a_card: assert property (p_card) else $error("card copy");
	property p_oe;
		!read_output_enable_n |-> any_cs && we_hi;
	endproperty
	a_oe: assert property (p_oe) else $error("read enable");
	property p_we;
		!we_hi |-> any_cs && read_output_enable_n;
	endproperty
	a_we: assert property (p_we) else $error("write strobe");
	property p_rel;
		cycle_done && !bus_strobe |=> !any_cs && read_output_enable_n && we_hi;
	endproperty
	a_rel: assert property (p_rel) else $error("no release");
	property p_done;
		$rose(cycle_done) |-> any_cs;
	endproperty
	a_done: assert property (p_done) else $error("done alone");
	property p_hold;
		any_cs && !cycle_done |=> $stable(chip_select_n);
	endproperty
	a_hold: assert property (p_hold) else $error("select moved");
	cover property ($rose(cycle_done) && !read_output_enable_n);
	cover property (!upper_byte_write_strobe_n && lower_byte_write_strobe_n);
	cover property (card_slot_select && cycle_done);
endmodule // csd_decoder_checker
bind csd_decoder csd_decoder_checker u_chk (.clock, .nrst, .bus_strobe, .chip_select_n,
	.boot_select, .card_slot_select, .read_output_enable_n, .upper_byte_write_strobe_n,
	.lower_byte_write_strobe_n, .cycle_done);
`default_nettype wire

// ### verif/csd_mem_model.sv
// Memory or peripheral that ends its cycles with the external acknowledge
`timescale 1ns/1ps
`default_nettype none
module csd_mem_model (
	input wire logic clock,
	input wire logic [15:0] chip_select_n,
	input wire logic [15:0] ext_sel,
	input wire logic [2:0] delay,
	output logic transfer_acknowledge_n
);
	logic [2:0] cnt_reg = 3'h0;
	initial transfer_acknowledge_n = 1'b1;
	// Pin is pulled up whenever no externally ended select is active
	always @(posedge clock) begin
		if ((~chip_select_n & ext_sel) == 16'h0) begin
			cnt_reg <= 3'h0;
			transfer_acknowledge_n <= 1'b1;
		end else if (cnt_reg >= delay) begin
			transfer_acknowledge_n <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
endmodule // csd_mem_model
`default_nettype wire

// ### verif/test_csd_decoder.sv
// Self-checking bench for the chip-select decoder
`timescale 1ns/1ps
`default_nettype none
module test_csd_decoder;
	logic clock = 1'b0, nrst = 1'b0, bus_strobe = 1'b0, cfg_load = 1'b0;
	logic bus_read = 1'b0, bus_upper = 1'b0, bus_lower = 1'b0;
	logic [31:0] bus_addr = 32'h0;
	logic [31:0] gbase [4], gmask [4], scmp [16], smask [16];
	logic [15:0] sen, swide, cs_n, ext;
	logic [2:0] swait [16];
	logic [2:0] dly = 3'h0;
	logic ack_n, boot, card, oe_n, uwe_n, lwe_n, done, wide;
	int fails = 0, checked = 0;
	always #2.5 clock = ~clock;
	always_comb begin
		for (int i = 0; i < 16; i++) ext[i] = swait[i] == 3'h7;
	end
	csd_mem_model u_mem (.clock, .chip_select_n(cs_n), .ext_sel(ext), .delay(dly),
		.transfer_acknowledge_n(ack_n));
	csd_decoder u_dut (.clock, .nrst, .bus_addr, .bus_strobe, .bus_read, .bus_upper, .bus_lower,
		.transfer_acknowledge_n(ack_n), .cfg_load, .cfg_group_base(gbase), .cfg_group_mask(gmask),
		.cfg_sel_cmp(scmp), .cfg_sel_mask(smask), .cfg_sel_enable(sen), .cfg_sel_wide(swide),
		.cfg_sel_wait(swait), .chip_select_n(cs_n), .boot_select(boot), .card_slot_select(card),
		.read_output_enable_n(oe_n), .upper_byte_write_strobe_n(uwe_n),
		.lower_byte_write_strobe_n(lwe_n), .cycle_done(done), .cycle_wide(wide));
	task automatic give_verdict();
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Groups A and B ignore 64K of offset, C and D only 4K
	function automatic int sel_of(logic [31:0] a);
		logic [31:0] g;
		for (int i = 0; i < 16; i++) begin
			g = (i < 8) ? 32'h0000_ffff : 32'h0000_0fff;
			if (sen[i] && ((a ^ gbase[i / 4]) & ~(gmask[i / 4] | g)) == 32'h0
				&& ((a ^ scmp[i]) & ~(smask[i] | g)) == 32'h0) return i;
		end
		return -1;
	endfunction
	task automatic do_reset();
		@(posedge clock);
		nrst <= 1'b0;
		sen <= 16'h1;
		swide <= 16'h1;
		gmask[0] <= 32'hffff_ffff;
		smask[0] <= 32'hffff_ffff;
		swait[0] <= 3'h6;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
	endtask
	task automatic load_random();
		@(posedge clock);
		for (int i = 0; i < 16; i++) begin
			gbase[i / 4] <= 32'(i / 4) << 28;
			gmask[i / 4] <= 32'h0fff_ffff;
			scmp[i] <= (32'(i / 4) << 28) | (32'(i % 4) << 20);
			smask[i] <= ($urandom % 2) ? 32'h000f_ffff : 32'h0;
			swait[i] <= 3'($urandom % 8);
		end
		sen <= 16'($urandom) | 16'h8000;
		swide <= 16'($urandom);
		cfg_load <= 1'b1;
		@(posedge clock);
		cfg_load <= 1'b0;
	endtask
	task automatic run(logic [31:0] a);
		int e, n;
		logic r, u, l;
		e = sel_of(a);
		r = 1'($urandom);
		u = 1'($urandom);
		l = 1'($urandom) | !u;
		@(posedge clock);
		{bus_addr, bus_read, bus_upper, bus_lower, bus_strobe} <= {a, r, u, l, 1'b1};
		dly <= 3'($urandom % 5);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (cs_n === 16'hffff && n < 4);
		check(cs_n, (e < 0) ? 16'hffff : 16'(~(16'h1 << e)));
		if (e >= 0) begin
			check({boot, card}, {e == 0, e == 15});
			check({oe_n, uwe_n, lwe_n, wide}, {!r, r | !(swide[e] & u),
				r | !(swide[e] ? l : 1'b1), swide[e]});
			n = 0;
			while (done !== 1'b1 && n < 40) begin
				@(negedge clock);
				n++;
			end
			check(swait[e] == 3'h7 ? done : n, swait[e] == 3'h7 ? 1 : swait[e] + 1);
		end
		@(posedge clock);
		bus_strobe <= 1'b0;
		repeat (3) @(negedge clock);
		check({cs_n, oe_n, uwe_n, lwe_n, done}, 20'hffffe);
	endtask
	initial begin
		void'($urandom(32'h52e5));
		for (int i = 0; i < 16; i++) begin
			scmp[i] = 32'h0;
			smask[i] = 32'h0;
			swait[i] = 3'h7;
			gbase[i / 4] = 32'h0;
			gmask[i / 4] = 32'h0;
		end
		sen = 16'h0;
		swide = 16'h0;
		do_reset();
		repeat (3) run($urandom);
		load_random();
		repeat (300) begin
			automatic int i = $urandom % 16;
			automatic int k = $urandom_range(12, 16);
			run((32'(i / 4) << 28) | (32'(i % 4) << 20) | ((32'h1 << k) - ($urandom % 2)));
		end
		do_reset();
		run($urandom);
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		give_verdict();
	end
endmodule // test_csd_decoder
`default_nettype wire
